/* File: hw/sbw_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SBW_REGS_SVH
`define SBW_REGS_SVH

// device i/o registers, offsets from the switch-chosen base
`define SBW_OFF_BANK 16'h0000
`define SBW_OFF_SOCKET 16'h0002
`define SBW_IO_BASE_SW_OFF 16'h0210
`define SBW_IO_BASE_SW_ON 16'h0290

// banked memory window, 8 KB each, base chosen by switch
`define SBW_WIN_BASE_SW_OFF 20'hd0000
`define SBW_WIN_BASE_SW_ON 20'hd8000
`define SBW_BANK_OFS_W 13
`define SBW_BANK_W 7

// bank register fields
`define SBW_WP_BIT 7
`define SBW_BANK_RESET 8'h00
// socket register fields
`define SBW_SOCK_LSB 2
`define SBW_SOCK_HI_NIBBLE 4'h1
`define SBW_SOCK_RESET 2'h0
`define SBW_OPEN_DATA 8'hff

// chip access timing at ref_clk
`define SBW_CLK_PERIOD_NS 25
`define SBW_ACCESS_NS 150
`define SBW_ACCESS_CYC ((`SBW_ACCESS_NS + `SBW_CLK_PERIOD_NS - 1) / `SBW_CLK_PERIOD_NS)
`define SBW_SYNC_CYC 2
`define SBW_ACK_TIMEOUT_CYC 32

// host controller command registers
`define SBW_H_BANK 5'h00
`define SBW_H_SOCKET 5'h04
`define SBW_H_OFFSET 5'h08
`define SBW_H_WRITE 5'h0c
`define SBW_H_READ 5'h10
`define SBW_H_STATUS 5'h14
`define SBW_H_RDATA 5'h18
`define SBW_H_IORD 5'h1c
// bank command fields
`define SBW_H_TYPE_LSB 0
`define SBW_H_NUM_LSB 8
`define SBW_H_WP_BIT 16

`endif

/* File: hw/sbw_pkg.sv */
// types shared by both ends of the bank window link
package sbw_pkg;
	typedef enum logic [2:0] {
		SBW_MT_64K = 3'h0,
		SBW_MT_128K = 3'h1,
		SBW_MT_256K = 3'h2,
		SBW_MT_512K = 3'h3,
		SBW_MT_1M = 3'h4,
		SBW_MT_SRAM128 = 3'h5,
		SBW_MT_SRAM512 = 3'h6
	} sbw_mem_type_t;

	typedef enum logic [1:0] {
		SBW_DS_IDLE = 2'h0,
		SBW_DS_ACCESS = 2'h1,
		SBW_DS_SETTLE = 2'h2,
		SBW_DS_ACK = 2'h3
	} sbw_dev_state_t;

	typedef enum logic [1:0] {
		SBW_HS_IDLE = 2'h0,
		SBW_HS_WAIT = 2'h1
	} sbw_host_state_t;
endpackage

/* File: hw/sbw_if.sv */
// isa-style i/o and memory cycles between host and bank window
`timescale 1ns/1ps
interface sbw_if;
	logic [15:0] io_addr;
	logic [7:0] io_wdata;
	logic io_wr;
	logic io_rd;
	logic [7:0] io_rdata;
	logic [19:0] mem_addr;
	logic [7:0] mem_wdata;
	logic mem_wr;
	logic mem_rd;
	logic [7:0] mem_rdata;
	logic mem_ack;

	modport device (
		input io_addr, io_wdata, io_wr, io_rd, mem_addr, mem_wdata, mem_wr, mem_rd,
		output io_rdata, mem_rdata, mem_ack
	);
	modport host (
		output io_addr, io_wdata, io_wr, io_rd, mem_addr, mem_wdata, mem_wr, mem_rd,
		input io_rdata, mem_rdata, mem_ack
	);
endinterface

/* File: hw/sbw_device.sv */
// bank window device: i/o registers, window decode, socket chip access
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "sbw_regs.svh"

module sbw_device #(
	parameter int ACCESS_CYC = `SBW_ACCESS_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	sbw_if.device bus,
	input wire logic io_base_switch,
	input wire logic window_range_switch,
	output logic [19:0] chip_addr,
	output logic [2:0] socket_enable_n,
	output logic chip_oe_n,
	output logic chip_we_n,
	output logic [7:0] chip_data_out,
	output logic chip_data_oe,
	input wire logic [7:0] chip_data_in,
	output logic write_protect_enable,
	output logic [1:0] socket_select
);
	import sbw_pkg::*;

	initial begin
		if (ACCESS_CYC < 1 || ACCESS_CYC > 255) begin
			$error("sbw_device: ACCESS_CYC out of range");
		end
	end

	// ==========================================================
	// switch and chip data synchronisers
	logic [1:0] base_sw_sync;
	logic [1:0] range_sw_sync;
	logic [7:0] rdata_meta;
	logic [7:0] rdata_sync;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			base_sw_sync <= 2'h0;
			range_sw_sync <= 2'h0;
			rdata_meta <= 8'h00;
			rdata_sync <= 8'h00;
		end else begin
			base_sw_sync <= {base_sw_sync[0], io_base_switch};
			range_sw_sync <= {range_sw_sync[0], window_range_switch};
			rdata_meta <= chip_data_in;
			rdata_sync <= rdata_meta;
		end
	end

	// ==========================================================
	// address decode
	logic [15:0] io_base;
	logic [19:0] win_base;
	logic hit_bank;
	logic hit_socket;
	logic hit_window;

	function automatic logic window_hit(input logic [19:0] addr, input logic [19:0] base);
		window_hit = addr[19:`SBW_BANK_OFS_W] == base[19:`SBW_BANK_OFS_W];
	endfunction

	always_comb begin
		io_base = base_sw_sync[1] ? `SBW_IO_BASE_SW_ON : `SBW_IO_BASE_SW_OFF;
		win_base = range_sw_sync[1] ? `SBW_WIN_BASE_SW_ON : `SBW_WIN_BASE_SW_OFF;
		hit_bank = bus.io_addr == io_base + `SBW_OFF_BANK;
		hit_socket = bus.io_addr == io_base + `SBW_OFF_SOCKET;
		hit_window = window_hit(bus.mem_addr, win_base);
	end

	// ==========================================================
	// i/o registers
	logic [7:0] bank_and_protect;
	logic [1:0] socket_choice;
	logic [7:0] io_rdata_q;
	logic [7:0] next_bank_and_protect;
	logic [1:0] next_socket_choice;
	logic [7:0] next_io_rdata;

	always_comb begin
		next_bank_and_protect = bank_and_protect;
		next_socket_choice = socket_choice;
		next_io_rdata = 8'h00;
		if (bus.io_wr && hit_bank) begin
			next_bank_and_protect = bus.io_wdata;
		end
		if (bus.io_wr && hit_socket) begin
			next_socket_choice = bus.io_wdata[`SBW_SOCK_LSB +: 2];
		end
		if (bus.io_rd && hit_bank) begin
			next_io_rdata = bank_and_protect;
		end else if (bus.io_rd && hit_socket) begin
			next_io_rdata = {`SBW_SOCK_HI_NIBBLE, socket_choice, 2'h0};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bank_and_protect <= `SBW_BANK_RESET;
			socket_choice <= `SBW_SOCK_RESET;
			io_rdata_q <= 8'h00;
		end else begin
			bank_and_protect <= next_bank_and_protect;
			socket_choice <= next_socket_choice;
			io_rdata_q <= next_io_rdata;
		end
	end

	assign bus.io_rdata = io_rdata_q;
	assign write_protect_enable = bank_and_protect[`SBW_WP_BIT];
	assign socket_select = socket_choice;

	// ==========================================================
	// memory cycle sequencer
	sbw_dev_state_t state;
	sbw_dev_state_t next_state;
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic is_write;
	logic next_is_write;
	logic [19:0] addr_q;
	logic [19:0] next_addr_q;
	logic [7:0] wdata_q;
	logic [7:0] next_wdata_q;
	logic [7:0] mem_rdata_q;
	logic [7:0] next_mem_rdata;
	logic [2:0] sock_en_q;
	logic [2:0] next_sock_en;
	logic oe_q;
	logic next_oe;
	logic we_q;
	logic next_we;
	logic drive_q;
	logic next_drive;

	function automatic logic [2:0] socket_decode(input logic [1:0] sel);
		case (sel)
			2'h1: socket_decode = 3'h1;
			2'h2: socket_decode = 3'h2;
			2'h3: socket_decode = 3'h4;
			default: socket_decode = 3'h0;
		endcase
	endfunction

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_is_write = is_write;
		next_addr_q = addr_q;
		next_wdata_q = wdata_q;
		next_mem_rdata = mem_rdata_q;
		next_sock_en = sock_en_q;
		next_oe = 1'b0;
		next_we = 1'b0;
		next_drive = 1'b0;
		case (state)
			SBW_DS_IDLE: begin
				if ((bus.mem_rd || bus.mem_wr) && hit_window) begin
					next_state = SBW_DS_ACCESS;
					next_cnt = 8'(ACCESS_CYC);
					next_is_write = bus.mem_wr;
					// one bank per access, numbered from zero on each chip
					next_addr_q = {bank_and_protect[`SBW_BANK_W-1:0],
						bus.mem_addr[`SBW_BANK_OFS_W-1:0]};
					next_wdata_q = bus.mem_wdata;
					next_sock_en = socket_decode(socket_choice);
					next_oe = ~bus.mem_wr;
					next_we = bus.mem_wr && !bank_and_protect[`SBW_WP_BIT];
					next_drive = bus.mem_wr;
				end
			end
			SBW_DS_ACCESS: begin
				next_oe = ~is_write;
				next_we = is_write && !bank_and_protect[`SBW_WP_BIT];
				next_drive = is_write;
				next_cnt = cnt - 8'h01;
				if (cnt == 8'h01) begin
					next_we = 1'b0;
					next_state = SBW_DS_SETTLE;
					next_cnt = 8'(`SBW_SYNC_CYC);
				end
			end
			SBW_DS_SETTLE: begin
				// hold oe until read data crossed the two sample flops
				next_oe = ~is_write;
				next_drive = is_write;
				next_cnt = cnt - 8'h01;
				if (cnt == 8'h01) begin
					next_state = SBW_DS_ACK;
					next_mem_rdata = sock_en_q == 3'h0 ? `SBW_OPEN_DATA : rdata_sync;
				end
			end
			SBW_DS_ACK: begin
				next_state = SBW_DS_IDLE;
				next_sock_en = 3'h0;
			end
			default: begin
				next_state = SBW_DS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= SBW_DS_IDLE;
			cnt <= 8'h00;
			is_write <= 1'b0;
			addr_q <= 20'h00000;
			wdata_q <= 8'h00;
			mem_rdata_q <= 8'h00;
			sock_en_q <= 3'h0;
			oe_q <= 1'b0;
			we_q <= 1'b0;
			drive_q <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			is_write <= next_is_write;
			addr_q <= next_addr_q;
			wdata_q <= next_wdata_q;
			mem_rdata_q <= next_mem_rdata;
			sock_en_q <= next_sock_en;
			oe_q <= next_oe;
			we_q <= next_we;
			drive_q <= next_drive;
		end
	end

	// chip strobes only reach an enabled socket
	assign chip_addr = addr_q;
	assign socket_enable_n = ~sock_en_q;
	assign chip_oe_n = ~(oe_q && sock_en_q != 3'h0);
	assign chip_we_n = ~(we_q && sock_en_q != 3'h0);
	assign chip_data_out = wdata_q;
	assign chip_data_oe = drive_q && sock_en_q != 3'h0;
	assign bus.mem_rdata = mem_rdata_q;
	assign bus.mem_ack = state == SBW_DS_ACK;
endmodule

/* File: hw/sbw_host.sv */
// host end: encodes bank fields and runs i/o and memory cycles
`timescale 1ns/1ps
`include "sbw_regs.svh"

module sbw_host #(
	parameter logic [15:0] IO_BASE = `SBW_IO_BASE_SW_OFF,
	parameter logic [19:0] WIN_BASE = `SBW_WIN_BASE_SW_OFF,
	parameter int ACK_TIMEOUT = `SBW_ACK_TIMEOUT_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	sbw_if.host bus,
	input wire logic [4:0] cmd_addr,
	input wire logic [31:0] cmd_wdata,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	output logic [31:0] cmd_rdata
);
	import sbw_pkg::*;

	initial begin
		if (ACK_TIMEOUT < 1 || ACK_TIMEOUT > 255) begin
			$error("sbw_host: ACK_TIMEOUT out of range");
		end
	end

	// ==========================================================
	// bank field encoding per memory type
	function automatic logic [6:0] encode_bank(input sbw_mem_type_t mt, input logic [6:0] b);
		case (mt)
			SBW_MT_64K: encode_bank = {4'h2, b[2:0]};
			SBW_MT_128K: encode_bank = {3'h0, b[3:0]};
			SBW_MT_256K: encode_bank = {1'b0, b[4], 1'b1, b[3:0]};
			SBW_MT_512K: encode_bank = {1'b0, b[4], b[5], b[3:0]};
			SBW_MT_1M: encode_bank = {b[6], b[4], b[5], b[3:0]};
			SBW_MT_SRAM128: encode_bank = {3'h2, b[3:0]};
			SBW_MT_SRAM512: encode_bank = {1'b0, b[5:0]};
			default: encode_bank = 7'h00;
		endcase
	endfunction

	// ==========================================================
	// command registers and cycle sequencer
	sbw_host_state_t state, next_state;
	logic bank_set, next_bank_set;
	logic socket_set, next_socket_set;
	logic [12:0] offset, next_offset;
	logic [7:0] rdata, next_rdata;
	logic [7:0] io_read, next_io_read;
	logic io_rd_pend, next_io_rd_pend;
	logic done, next_done;
	logic timeout, next_timeout;
	logic refused, next_refused;
	logic [7:0] cnt, next_cnt;
	logic [15:0] io_addr_q, next_io_addr;
	logic [7:0] io_wdata_q, next_io_wdata;
	logic io_wr_q, next_io_wr;
	logic io_rd_q, next_io_rd;
	logic [7:0] mem_wdata_q, next_mem_wdata;
	logic mem_wr_q, next_mem_wr;
	logic mem_rd_q, next_mem_rd;
	logic [31:0] rd_q, next_rd;
	logic idle;

	always_comb begin
		idle = state == SBW_HS_IDLE && !io_wr_q && !io_rd_q;
		next_state = state;
		next_bank_set = bank_set;
		next_socket_set = socket_set;
		next_offset = offset;
		next_rdata = rdata;
		next_io_read = io_read;
		next_io_rd_pend = io_rd_q;
		next_done = done;
		next_timeout = timeout;
		next_refused = refused;
		next_cnt = cnt;
		next_io_addr = io_addr_q;
		next_io_wdata = io_wdata_q;
		next_io_wr = 1'b0;
		next_io_rd = 1'b0;
		next_mem_wdata = mem_wdata_q;
		next_mem_wr = 1'b0;
		next_mem_rd = 1'b0;
		next_rd = 32'h0;
		if (io_rd_pend) begin
			next_io_read = bus.io_rdata;
		end
		if (cmd_wr && idle) begin
			case (cmd_addr)
				`SBW_H_BANK: begin
					next_io_addr = IO_BASE + `SBW_OFF_BANK;
					next_io_wdata = {cmd_wdata[`SBW_H_WP_BIT], encode_bank(
						sbw_mem_type_t'(cmd_wdata[`SBW_H_TYPE_LSB +: 3]),
						cmd_wdata[`SBW_H_NUM_LSB +: 7])};
					next_io_wr = 1'b1;
					next_bank_set = 1'b1;
				end
				`SBW_H_SOCKET: begin
					next_io_addr = IO_BASE + `SBW_OFF_SOCKET;
					next_io_wdata = {4'h0, cmd_wdata[1:0], 2'h0};
					next_io_wr = 1'b1;
					next_socket_set = 1'b1;
				end
				`SBW_H_OFFSET: next_offset = cmd_wdata[12:0];
				`SBW_H_WRITE, `SBW_H_READ: begin
					next_done = 1'b0;
					next_timeout = 1'b0;
					if (bank_set && socket_set) begin
						next_refused = 1'b0;
						next_mem_wdata = cmd_wdata[7:0];
						next_mem_wr = cmd_addr == `SBW_H_WRITE;
						next_mem_rd = cmd_addr == `SBW_H_READ;
						next_cnt = 8'(ACK_TIMEOUT);
						next_state = SBW_HS_WAIT;
					end else begin
						next_refused = 1'b1;
					end
				end
				`SBW_H_IORD: begin
					next_io_addr = cmd_wdata[1] ? IO_BASE + `SBW_OFF_SOCKET
						: IO_BASE + `SBW_OFF_BANK;
					next_io_rd = 1'b1;
				end
				default: begin
				end
			endcase
		end
		if (state == SBW_HS_WAIT && !mem_wr_q && !mem_rd_q) begin
			next_cnt = cnt - 8'h01;
			if (bus.mem_ack) begin
				next_rdata = bus.mem_rdata;
				next_done = 1'b1;
				next_state = SBW_HS_IDLE;
			end else if (cnt == 8'h01) begin
				next_timeout = 1'b1;
				next_state = SBW_HS_IDLE;
			end
		end
		if (cmd_rd) begin
			case (cmd_addr)
				`SBW_H_STATUS: next_rd = {28'h0, refused, timeout, done, !idle};
				`SBW_H_RDATA: next_rd = {24'h0, rdata};
				`SBW_H_IORD: next_rd = {24'h0, io_read};
				default: next_rd = 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= SBW_HS_IDLE;
			bank_set <= 1'b0;
			socket_set <= 1'b0;
			offset <= 13'h0000;
			rdata <= 8'h00;
			io_read <= 8'h00;
			io_rd_pend <= 1'b0;
			done <= 1'b0;
			timeout <= 1'b0;
			refused <= 1'b0;
			cnt <= 8'h00;
			io_addr_q <= 16'h0000;
			io_wdata_q <= 8'h00;
			io_wr_q <= 1'b0;
			io_rd_q <= 1'b0;
			mem_wdata_q <= 8'h00;
			mem_wr_q <= 1'b0;
			mem_rd_q <= 1'b0;
			rd_q <= 32'h0;
		end else begin
			state <= next_state;
			bank_set <= next_bank_set;
			socket_set <= next_socket_set;
			offset <= next_offset;
			rdata <= next_rdata;
			io_read <= next_io_read;
			io_rd_pend <= next_io_rd_pend;
			done <= next_done;
			timeout <= next_timeout;
			refused <= next_refused;
			cnt <= next_cnt;
			io_addr_q <= next_io_addr;
			io_wdata_q <= next_io_wdata;
			io_wr_q <= next_io_wr;
			io_rd_q <= next_io_rd;
			mem_wdata_q <= next_mem_wdata;
			mem_wr_q <= next_mem_wr;
			mem_rd_q <= next_mem_rd;
			rd_q <= next_rd;
		end
	end

	assign bus.io_addr = io_addr_q;
	assign bus.io_wdata = io_wdata_q;
	assign bus.io_wr = io_wr_q;
	assign bus.io_rd = io_rd_q;
	assign bus.mem_addr = {WIN_BASE[19:`SBW_BANK_OFS_W], offset};
	assign bus.mem_wdata = mem_wdata_q;
	assign bus.mem_wr = mem_wr_q;
	assign bus.mem_rd = mem_rd_q;
	assign cmd_rdata = rd_q;
endmodule

/* File: dv/sbw_link_properties.sv */
// concurrent checks on the signals of the bank window link
`timescale 1ns/1ps
module sbw_link_properties #(
	parameter logic [15:0] IO_BASE = 16'h0210
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_rdata,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic mem_ack
);
	logic seen_bank;
	logic seen_sock;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ==========================================
	// which registers the host has programmed
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			seen_bank <= 1'b0;
			seen_sock <= 1'b0;
		end else if (io_wr) begin
			seen_bank <= seen_bank | (io_addr == IO_BASE);
			seen_sock <= seen_sock | (io_addr == IO_BASE + 16'h0002);
		end
	end

	// ==========================================
	// properties
	a_ack_latency: assert property (mem_ack |-> $past(mem_rd || mem_wr, 9))
		else $error("memory ack not nine cycles after its strobe");
	a_ack_pulse: assert property (mem_ack |=> !mem_ack)
		else $error("memory ack longer than one cycle");
	a_strobe_gap: assert property ((mem_rd || mem_wr) |=> !(mem_rd || mem_wr) [*8])
		else $error("memory strobe issued while access busy");
	a_mem_excl: assert property (!(mem_rd && mem_wr))
		else $error("memory read and write strobes together");
	a_bank_first: assert property ((mem_rd || mem_wr) |-> seen_bank && seen_sock)
		else $error("memory cycle before bank and socket programmed");
	a_io_idle_zero: assert property (!$past(io_rd) |-> io_rdata == 8'h00)
		else $error("io read data outside its cycle");
	a_sock_format: assert property ($past(io_rd) && $past(io_addr) == IO_BASE + 16'h0002
		|-> io_rdata[7:4] == 4'h1 && io_rdata[1:0] == 2'h0)
		else $error("socket register fixed bits wrong");
	a_io_pulse: assert property (io_wr |=> !io_wr)
		else $error("io write strobe longer than one cycle");
endmodule

/* File: dv/ssd_bank_window_select_tb_top.sv */
// self-checking bench: host end and device end joined by the link
`timescale 1ns/1ps
`include "sbw_regs.svh"
module ssd_bank_window_select_tb_top;
	import sbw_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic io_base_switch = 1'b0;
	logic window_range_switch = 1'b0;
	logic [4:0] cmd_addr = 5'h00;
	logic [31:0] cmd_wdata = 32'h0;
	logic cmd_wr = 1'b0;
	logic cmd_rd = 1'b0;
	logic [31:0] cmd_rdata;
	logic [19:0] chip_addr;
	logic [2:0] socket_enable_n;
	logic chip_oe_n;
	logic chip_we_n;
	logic [7:0] chip_data_out;
	logic chip_data_oe;
	logic [7:0] chip_data_in = 8'h00;
	logic write_protect_enable;
	logic [1:0] socket_select;
	int bad_count = 0;
	int n_checks = 0;
	int we_count = 0;
	int nbits [7] = '{3, 4, 5, 6, 7, 4, 6};
	logic [31:0] lfsr = 32'h59762b74;
	logic [7:0] chip_mem [int];
	logic [7:0] exp_mem [int];
	logic [19:0] seen_addr = 20'h0;
	logic [2:0] seen_en = 3'h7;

	always #12.5 ref_clk = ~ref_clk;

	sbw_if link ();
	sbw_host #(.ACK_TIMEOUT(12)) i_sbw_host (.ref_clk(ref_clk), .rst(rst), .bus(link),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_rdata(cmd_rdata));
	sbw_device i_sbw_device (.ref_clk(ref_clk), .rst(rst), .bus(link),
		.io_base_switch(io_base_switch), .window_range_switch(window_range_switch),
		.chip_addr(chip_addr), .socket_enable_n(socket_enable_n), .chip_oe_n(chip_oe_n),
		.chip_we_n(chip_we_n), .chip_data_out(chip_data_out), .chip_data_oe(chip_data_oe),
		.chip_data_in(chip_data_in), .write_protect_enable(write_protect_enable),
		.socket_select(socket_select));
	sbw_link_properties i_sbw_link_properties (.ref_clk(ref_clk), .rst(rst),
		.io_addr(link.io_addr), .io_wr(link.io_wr), .io_rd(link.io_rd),
		.io_rdata(link.io_rdata), .mem_wr(link.mem_wr), .mem_rd(link.mem_rd),
		.mem_ack(link.mem_ack));

	// ==========================================
	// socketed chip model, data line toggles when not read
	always @(posedge ref_clk) begin
		if (socket_enable_n != 3'b111) begin
			seen_addr <= chip_addr;
			seen_en <= socket_enable_n;
		end
		if (socket_enable_n != 3'b111 && !chip_we_n && chip_data_oe) begin
			chip_mem[{socket_enable_n, chip_addr}] = chip_data_out;
			we_count++;
		end
		if (socket_enable_n != 3'b111 && !chip_oe_n)
			chip_data_in <= chip_mem.exists({socket_enable_n, chip_addr}) ?
				chip_mem[{socket_enable_n, chip_addr}] : 8'h3c;
		else
			chip_data_in <= ~chip_data_in;
	end

	// ==========================================
	// helpers
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
		return lfsr;
	endfunction

	function automatic logic [7:0] enc(input int t, input logic [6:0] n, input logic wp);
		logic [6:0] f;
		case (t)
			0: f = {4'b0010, n[2:0]};
			1: f = {3'b000, n[3:0]};
			2: f = {1'b0, n[4], 1'b1, n[3:0]};
			3: f = {1'b0, n[4], n[5], n[3:0]};
			4: f = {n[6], n[4], n[5], n[3:0]};
			5: f = {3'b010, n[3:0]};
			default: f = {1'b0, n[5:0]};
		endcase
		return {wp, f};
	endfunction

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cmd_write(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_wr <= 1'b1;
		@(posedge ref_clk);
		cmd_wr <= 1'b0;
	endtask

	task automatic cmd_read(input logic [4:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		cmd_addr <= a;
		cmd_rd <= 1'b1;
		@(posedge ref_clk);
		cmd_rd <= 1'b0;
		#1 d = cmd_rdata;
	endtask

	task automatic wait_idle();
		logic [31:0] s;
		int i;
		s = 32'h1;
		for (i = 0; i < 60 && s[0] !== 1'b0; i++)
			cmd_read(`SBW_H_STATUS, s);
		if (s[0] !== 1'b0) begin
			check(s, 32'h0);
			finish_test();
		end
	endtask

	task automatic io_read(input logic sel, output logic [31:0] r);
		cmd_write(`SBW_H_IORD, {30'h0, sel, 1'b0});
		repeat (2) @(posedge ref_clk);
		cmd_read(`SBW_H_IORD, r);
	endtask

	task automatic mem_op(input logic wr, input logic [12:0] ofs, input logic [7:0] d,
		output logic [31:0] r);
		cmd_write(`SBW_H_OFFSET, {19'h0, ofs});
		cmd_write(wr ? `SBW_H_WRITE : `SBW_H_READ, {24'h0, d});
		wait_idle();
		cmd_read(`SBW_H_RDATA, r);
	endtask

	task automatic set_bank(input int t, input logic [6:0] n, input logic wp);
		cmd_write(`SBW_H_BANK, {15'h0, wp, 1'b0, n, 5'h0, t[2:0]});
		wait_idle();
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		check(32'h0, 32'h1);
		finish_test();
	end

	// ==========================================
	// main sequence
	initial begin
		logic [31:0] r;
		logic [7:0] b;
		logic [7:0] d;
		logic [12:0] ofs;
		logic [6:0] n;
		logic [2:0] en;
		int t;
		int s;
		int k;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check(write_protect_enable, 32'h0);
		check(socket_select, 32'h0);
		io_read(1'b1, r);
		check(r[7:0], 8'h10);
		cmd_write(`SBW_H_READ, 32'h0);
		wait_idle();
		cmd_read(`SBW_H_STATUS, r);
		check(r[3], 1'b1);
		for (t = 0; t < 7; t++) begin
			s = t % 3 + 1;
			n = (t == 2) ? 7'd31 : 7'(rnd() & ((1 << nbits[t]) - 1));
			b = enc(t, n, 1'b0);
			set_bank(t, n, 1'b0);
			cmd_write(`SBW_H_SOCKET, s);
			wait_idle();
			io_read(1'b0, r);
			check(r[7:0], b);
			io_read(1'b1, r);
			check(r[7:0], {4'h1, s[1:0], 2'h0});
			check(socket_select, s);
			ofs = 13'(rnd());
			d = 8'(rnd());
			mem_op(1'b1, ofs, d, r);
			check(socket_enable_n, 32'h7);
			en = ~(3'b001 << (s - 1));
			check(seen_addr, {b[6:0], ofs});
			check(seen_en, en);
			exp_mem[{s[1:0], b[6:0], ofs}] = d;
			mem_op(1'b0, ofs, 8'h00, r);
			check(r[7:0], exp_mem[{s[1:0], b[6:0], ofs}]);
		end
		set_bank(6, n, 1'b1);
		check(write_protect_enable, 32'h1);
		k = we_count;
		mem_op(1'b1, ofs, ~d, r);
		check(we_count, k);
		mem_op(1'b0, ofs, 8'h00, r);
		check(r[7:0], exp_mem[{s[1:0], b[6:0], ofs}]);
		cmd_write(`SBW_H_SOCKET, 32'h0);
		wait_idle();
		mem_op(1'b0, ofs, 8'h00, r);
		check(r[7:0], 8'hff);
		@(posedge ref_clk);
		io_base_switch <= 1'b1;
		repeat (4) @(posedge ref_clk);
		set_bank(6, n, 1'b0);
		repeat (2) @(posedge ref_clk);
		check(write_protect_enable, 32'h1);
		io_base_switch <= 1'b0;
		window_range_switch <= 1'b1;
		repeat (4) @(posedge ref_clk);
		cmd_write(`SBW_H_SOCKET, s);
		wait_idle();
		mem_op(1'b0, ofs, 8'h00, r);
		cmd_read(`SBW_H_STATUS, r);
		check(r[2], 1'b1);
		@(posedge ref_clk);
		window_range_switch <= 1'b0;
		repeat (4) @(posedge ref_clk);
		mem_op(1'b0, ofs, 8'h00, r);
		check(r[7:0], exp_mem[{s[1:0], b[6:0], ofs}]);
		finish_test();
	end
endmodule
